/* File: rap_alarm_match.sv */
// masked comparison of calendar digits against alarm digits
`timescale 1ns/1ps
`include "rap_regs.svh"

module rap_alarm_match (
   input  rap_pkg::rap_caltime_t now_i,
   input  rap_pkg::rap_caltime_t alm_i,
   input  wire logic [3:0]       mask_i,
   input  wire logic             half_i,
   output logic                  hit_o
);

   logic so, st, mo, mt, hr, wd, dy, mn, leap;

   always_comb begin
      so   = now_i.timel[11:8] == alm_i.timel[11:8];
      st   = now_i.timel[14:12] == alm_i.timel[14:12];
      mo   = now_i.timeh[3:0] == alm_i.timeh[3:0];
      mt   = now_i.timeh[6:4] == alm_i.timeh[6:4];
      hr   = now_i.timeh[13:8] == alm_i.timeh[13:8];
      wd   = now_i.datel[2:0] == alm_i.datel[2:0];
      dy   = now_i.datel[13:8] == alm_i.datel[13:8];
      mn   = now_i.dateh[4:0] == alm_i.dateh[4:0];
      // a yearly alarm on feb 29 is suppressed in every year, leap years included
      leap = alm_i.dateh[4:0] == `RAP_FEB && alm_i.datel[13:8] == `RAP_DAY29;
      // whole seconds: only the first half of each second may fire
      case (mask_i) // see (RL3)
         `RAP_MASK_HALF:  hit_o = 1'b1;
         `RAP_MASK_SEC:   hit_o = !half_i;
         `RAP_MASK_SEC10: hit_o = !half_i && so;
         `RAP_MASK_MIN:   hit_o = !half_i && so && st;
         `RAP_MASK_MIN10: hit_o = !half_i && so && st && mo;
         `RAP_MASK_HOUR:  hit_o = !half_i && so && st && mo && mt;
         `RAP_MASK_DAY:   hit_o = !half_i && so && st && mo && mt && hr;
         `RAP_MASK_WEEK:  hit_o = !half_i && so && st && mo && mt && hr && wd;
         `RAP_MASK_MONTH: hit_o = !half_i && so && st && mo && mt && hr && dy;
         `RAP_MASK_YEAR:  hit_o = !half_i && so && st && mo && mt && hr && dy && mn && !leap;
         default:         hit_o = 1'b0;
      endcase
   end

endmodule // rap_alarm_match

/* File: rap_peer_model.sv */
// model of the switched external device that wakes the block on power-up
`timescale 1ns/1ps
module rap_peer_model (
   input  wire logic clock_i,
   input  wire logic supply_i,
   output logic      wake_n_o
);
   logic [2:0] up_cnt = 3'h0;
   // one short wake pulse per power-up, once the supply has settled
   always @(posedge clock_i) begin
      if (!supply_i) up_cnt <= 3'h0;
      else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
   end
   // pin has a pull-up: high whenever the pulse is not driven
   assign wake_n_o = !(up_cnt == 3'h3 || up_cnt == 3'h4);
endmodule // rap_peer_model

/* File: rap_pkg.sv */
// types shared by the alarm/power/timestamp block
package rap_pkg;

   // ----------------------------------------------------------------------
   // calendar words (bcd)
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] dateh;
      logic [15:0] datel;
      logic [15:0] timeh;
      logic [15:0] timel;
   } rap_caltime_t;

   typedef enum logic [1:0] {PW_IDLE, PW_STAB, PW_SAMP} rap_pw_t;

   // ----------------------------------------------------------------------
   // complete state of the top module
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic         cal_en;
      logic         pwc_en;
      logic         pwc_pol;
      logic         pin_oe;
      logic [2:0]   outsel;
      logic         ts_en;
      logic         alm_en;
      logic         chime;
      logic [3:0]   mask;
      logic [7:0]   rpt;
      logic [1:0]   ps;
      logic [7:0]   samp_len;
      logic [7:0]   stab_len;
      logic         ts_flag;
      logic         ts_pend;
      rap_caltime_t alm;
      rap_caltime_t cap;
      rap_pw_t      pw;
      logic [7:0]   win_cnt;
      logic [2:0]   tmp_sync;
      logic         bus_act;
      logic         bus_wr;
      logic [8:0]   bus_idx;
      logic [31:0]  rdata;
      logic         alm_pulse;
      logic         cal_irq;
   } rap_state_t;

endpackage

/* File: rap_pwc_prescale.sv */
// prescaler of the power-control clock enable
`timescale 1ns/1ps
`include "rap_regs.svh"

module rap_pwc_prescale (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       tick_i,
   input  wire logic [1:0] ps_i,
   input  wire logic       clear_i,
   output logic            tick_o
);

   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic [7:0] term;

   always_comb begin
      case (ps_i)
         2'h0:    term = `RAP_PS_TERM1;
         2'h1:    term = `RAP_PS_TERM16;
         2'h2:    term = `RAP_PS_TERM64;
         default: term = `RAP_PS_TERM256;
      endcase
      tick_o   = tick_i && (cnt_reg == term); // see (RL14)
      cnt_next = cnt_reg;
      if (clear_i) begin
         cnt_next = 8'h00;
      end else if (tick_o) begin
         cnt_next = 8'h00;
      end else if (tick_i) begin
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   a_ps_div16 : assert property (@(posedge clock_i) disable iff (rst_i)
      tick_i && ps_i == 2'h1 && !clear_i
      |=> cnt_reg == (($past(cnt_reg) == 8'h0f) ? 8'h00 : $past(cnt_reg) + 8'h01)) // see (RL14)
      else $error("prescaler 1:16 fired at wrong count");

endmodule // rap_pwc_prescale

/* File: rap_regs.svh */
// register indices, field positions, codes and reset values of the alarm/power/timestamp block
`ifndef RAP_REGS_SVH
`define RAP_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define RAP_IDX_CAL_CTRL_LO  9'h1cc
`define RAP_IDX_ALM_CTRL_HI  9'h1ce
`define RAP_IDX_CLK_CFG_LO   9'h1d0
`define RAP_IDX_PWR_WIN      9'h1d4
`define RAP_IDX_STATUS_LO    9'h1d8
`define RAP_IDX_ALM_TIME_LO  9'h1e4
`define RAP_IDX_ALM_TIME_HI  9'h1e6
`define RAP_IDX_ALM_DATE_LO  9'h1e8
`define RAP_IDX_ALM_DATE_HI  9'h1ea
`define RAP_IDX_CAP_TIME_LO  9'h1ec
`define RAP_IDX_CAP_TIME_HI  9'h1ee
`define RAP_IDX_CAP_DATE_LO  9'h1f0
`define RAP_IDX_CAP_DATE_HI  9'h1f2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RAP_CC_CAL_EN   15
`define RAP_CC_PWC_EN   10
`define RAP_CC_PWC_POL  9
`define RAP_CC_PIN_OE   7
`define RAP_CC_OUTSEL   6:4
`define RAP_CC_TS_EN    0
`define RAP_AC_ALM_EN   15
`define RAP_AC_CHIME    14
`define RAP_AC_MASK     11:8
`define RAP_AC_RPT      7:0
`define RAP_CF_PWC_PS   7:6
`define RAP_PW_SAMP     15:8
`define RAP_PW_STAB     7:0
`define RAP_ST_TS_EVT   3

// ----------------------------------------------------------------------
// codes and values
// ----------------------------------------------------------------------
`define RAP_OUTSEL_PWC  3'h3
`define RAP_WIN_OFF     8'h00
`define RAP_WIN_HOLD    8'hff
`define RAP_RPT_LAST    8'h00
`define RAP_RPT_ROLL    8'hff
`define RAP_PS_TERM1    8'h00
`define RAP_PS_TERM16   8'h0f
`define RAP_PS_TERM64   8'h3f
`define RAP_PS_TERM256  8'hff
`define RAP_MASK_HALF   4'h0
`define RAP_MASK_SEC    4'h1
`define RAP_MASK_SEC10  4'h2
`define RAP_MASK_MIN    4'h3
`define RAP_MASK_MIN10  4'h4
`define RAP_MASK_HOUR   4'h5
`define RAP_MASK_DAY    4'h6
`define RAP_MASK_WEEK   4'h7
`define RAP_MASK_MONTH  4'h8
`define RAP_MASK_YEAR   4'h9
`define RAP_FEB         5'h02
`define RAP_DAY29       6'h29
`define RAP_RST_WORD    16'h0000

`endif

/* File: rap_tb.sv */
// testbench of the alarm, power-control and timestamp block
`timescale 1ns/1ps
`include "rap_regs.svh"
module rtc_alarm_power_timestamp_tb;
   logic        clock_i = 0, rst_i = 1, hsel = 0, hwrite = 0, half = 0, pwc = 0, por = 1;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic        hready, cirq, airq, pctl, sgate, stab, cpoe, tmp_n, cen, cpin, hresp;
   logic [15:0] cyc = 16'h0;
   int          num_errors = 0, tests_run = 0, alarms = 0, cirqs = 0, st_t = 0, sa_t = 0;
   rap_pkg::rap_caltime_t now = 64'h0024_0815_0012_3456;
   always #2 clock_i = ~clock_i;
   rap_top DUT (.clock_i(clock_i), .rst_i(rst_i), .por_i(por), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .cal_time_i(now), .halfsec_tick_i(half), .half_phase_i(1'b0),
      .pwc_tick_i(pwc), .tamper_input_n_i(tmp_n), .calendar_enable_o(cen),
      .alarm_irq_o(airq), .calendar_irq_o(cirq), .power_ctrl_o(pctl),
      .sample_gate_o(sgate), .stab_window_o(stab), .clock_pin_o(cpin),
      .clock_pin_oe_o(cpoe));
   rap_peer_model peer (.clock_i(clock_i), .supply_i(pctl), .wake_n_o(tmp_n));
   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {21'h0, idx, 2'h0};
      do @(posedge clock_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------------
   // tick sources, event counters, timeout
   // ----------------------------------------------------------------------
   always @(posedge clock_i) begin
      cyc <= cyc + 16'h1;
      half <= (cyc[5:0] == 6'h3f);
      pwc <= (cyc[1:0] == 2'h3);
      alarms <= alarms + int'(airq);
      cirqs <= cirqs + int'(cirq);
      if (pwc && stab && !sgate) st_t <= st_t + 1;
      if (pwc && sgate) sa_t <= sa_t + 1;
      if (cyc == 16'h4e20) begin
         num_errors++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      chk(pctl, 1);
      bus(0, 9'h1d6, 0);
      chk(rd, 0);
      bus(1, `RAP_IDX_CAL_CTRL_LO, 32'h8001);
      bus(1, `RAP_IDX_STATUS_LO, 32'h8);
      rd = 0;
      for (int i = 0; i < 20 && !rd[3]; i++) bus(0, `RAP_IDX_STATUS_LO, 0);
      chk(rd, 32'h8);
      @(posedge clock_i);
      chk(cirqs, 1);
      bus(0, `RAP_IDX_CAP_TIME_LO, 0);
      chk(rd, 32'h3456);
      bus(0, `RAP_IDX_CAP_DATE_HI, 0);
      chk(rd, 32'h0024);
      bus(1, `RAP_IDX_STATUS_LO, 0);
      bus(1, `RAP_IDX_ALM_CTRL_HI, 32'h8000);
      repeat (192) @(posedge clock_i);
      chk(alarms, 1);
      bus(0, `RAP_IDX_ALM_CTRL_HI, 0);
      chk(rd, 0);
      bus(1, `RAP_IDX_ALM_CTRL_HI, 32'h8002);
      repeat (320) @(posedge clock_i);
      chk(alarms, 4);
      bus(1, `RAP_IDX_ALM_CTRL_HI, 32'hc000);
      for (int i = 0; i < 80 && alarms == 4; i++) @(posedge clock_i);
      bus(0, `RAP_IDX_ALM_CTRL_HI, 0);
      chk(rd, 32'hc0ff);
      bus(1, `RAP_IDX_ALM_CTRL_HI, 0);
      bus(1, `RAP_IDX_ALM_TIME_LO, 32'h0);
      bus(1, `RAP_IDX_CLK_CFG_LO, 32'hc0);
      bus(0, `RAP_IDX_CLK_CFG_LO, 0);
      chk(rd, 32'hc0);
      bus(1, `RAP_IDX_CLK_CFG_LO, 0);
      bus(1, `RAP_IDX_PWR_WIN, 32'h0302);
      bus(1, `RAP_IDX_CAL_CTRL_LO, 32'h86b1);
      bus(1, `RAP_IDX_ALM_CTRL_HI, 32'hc000);
      for (int i = 0; i < 200 && alarms < 7; i++) @(posedge clock_i);
      chk({hresp, cpin, cen}, 3'h3);
      repeat (32) @(posedge clock_i);
      chk(alarms, 7);
      chk(st_t, 4);
      chk(sa_t, 6);
      chk(pctl, 0);
      chk(cpoe, 1);
      chk(cirqs, 2);
      por <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      bus(0, `RAP_IDX_CAP_TIME_LO, 0);
      chk(rd, 32'h3456);
      stop_test();
   end
endmodule // rtc_alarm_power_timestamp_tb

/* File: rap_top.sv */
// alarm, power-control sequencer and timestamp capture with ahb-lite registers
//
// Contract
// (RL1) alarm enable clears itself on an alarm unless repeating continues
// (RL2) software writes alarm values only while alarm enable is zero
// (RL3) four-bit mask picks compared digits; yearly skips feb 29
// (RL4) count zero and chime clear gives exactly one alarm
// (RL5) each alarm decrements count; at zero one last alarm then disable
// (RL6) chime set: count zero rolls to ff, alarms never stop
// (RL7) every alarm pulses a synchronous interrupt output
// (RL8) while enabled software changes only pin enable, count and chime
// (RL9) software enables calendar, power control, pin, and select 011
// (RL10) power control output polarity follows the polarity bit
// (RL11) software sets chime so power cycles recur on alarms
// (RL12) cycle: output on, stability window, then sample gate, then off
// (RL13) window lengths 0 to 255 prescaled periods, sample high byte
// (RL14) prescale divides power clock by 1, 16, 64 or 256
// (RL15) a window length of zero leaves that window inactive
// (RL16) stability length ff keeps stability window on, even disabled
// (RL17) enabled timestamping captures on a low pulse of tamper input
// (RL18) capture copies time and date, sets flag, raises calendar interrupt
// (RL19) captures ignored while flag set; software clears flag after reading
// (RL20) disabled timestamping: capture words are storage, kept but for power-on
// (RL21) writing 1 to flag starts capture; flag sets when capture is done
// (RL22) software polls the flag to see a manual capture finish
// (RL23) calendar enable lets the calendar count; clear stops it
// (RL24) alarm compare evaluated once per half-second tick
`timescale 1ns/1ps
`include "rap_regs.svh"

module rap_top (
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   input  wire logic             por_i,
   input  wire logic             hsel_i,
   input  wire logic [31:0]      haddr_i,
   input  wire logic [1:0]       htrans_i,
   input  wire logic             hwrite_i,
   input  wire logic [2:0]       hsize_i,
   input  wire logic [31:0]      hwdata_i,
   input  wire logic             hready_i,
   output logic [31:0]           hrdata_o,
   output logic                  hreadyout_o,
   output logic                  hresp_o,
   input  rap_pkg::rap_caltime_t cal_time_i,
   input  wire logic             halfsec_tick_i,
   input  wire logic             half_phase_i,
   input  wire logic             pwc_tick_i,
   input  wire logic             tamper_input_n_i,
   output logic                  calendar_enable_o,
   output logic                  alarm_irq_o,
   output logic                  calendar_irq_o,
   output logic                  power_ctrl_o,
   output logic                  sample_gate_o,
   output logic                  stab_window_o,
   output logic                  clock_pin_o,
   output logic                  clock_pin_oe_o
);

   localparam rap_pkg::rap_state_t RST_VAL = '0;

   rap_pkg::rap_state_t r_reg;
   rap_pkg::rap_state_t r_next;
   logic                hit;
   logic                ps_tick;
   logic                alm_fire;
   logic                pw_start;
   logic                tmp_fall;
   logic                ts_trig;
   logic                wr_stat;
   logic                pw_act;

   // ----------------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------------
   function automatic logic [31:0] rap_read(input rap_pkg::rap_state_t s,
                                            input logic [8:0] idx);
      logic [15:0] v;
      v = `RAP_RST_WORD;
      case (idx)
         `RAP_IDX_CAL_CTRL_LO: begin
            v[`RAP_CC_CAL_EN]  = s.cal_en;
            v[`RAP_CC_PWC_EN]  = s.pwc_en;
            v[`RAP_CC_PWC_POL] = s.pwc_pol;
            v[`RAP_CC_PIN_OE]  = s.pin_oe;
            v[`RAP_CC_OUTSEL]  = s.outsel;
            v[`RAP_CC_TS_EN]   = s.ts_en;
         end
         `RAP_IDX_ALM_CTRL_HI: begin
            v[`RAP_AC_ALM_EN] = s.alm_en;
            v[`RAP_AC_CHIME]  = s.chime;
            v[`RAP_AC_MASK]   = s.mask;
            v[`RAP_AC_RPT]    = s.rpt;
         end
         `RAP_IDX_CLK_CFG_LO:  v[`RAP_CF_PWC_PS] = s.ps;
         `RAP_IDX_PWR_WIN:     v = {s.samp_len, s.stab_len};
         `RAP_IDX_STATUS_LO:   v[`RAP_ST_TS_EVT] = s.ts_flag;
         `RAP_IDX_ALM_TIME_LO: v = s.alm.timel;
         `RAP_IDX_ALM_TIME_HI: v = s.alm.timeh;
         `RAP_IDX_ALM_DATE_LO: v = s.alm.datel;
         `RAP_IDX_ALM_DATE_HI: v = s.alm.dateh;
         `RAP_IDX_CAP_TIME_LO: v = s.cap.timel;
         `RAP_IDX_CAP_TIME_HI: v = s.cap.timeh;
         `RAP_IDX_CAP_DATE_LO: v = s.cap.datel;
         `RAP_IDX_CAP_DATE_HI: v = s.cap.dateh;
         default:              v = `RAP_RST_WORD;
      endcase
      return {16'h0000, v};
   endfunction

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   rap_alarm_match u_match (
      .now_i  (cal_time_i),
      .alm_i  (r_reg.alm),
      .mask_i (r_reg.mask),
      .half_i (half_phase_i),
      .hit_o  (hit)
   );

   rap_pwc_prescale u_ps (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .tick_i  (pwc_tick_i),
      .ps_i    (r_reg.ps),
      .clear_i (pw_start),
      .tick_o  (ps_tick)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      r_next           = r_reg;
      r_next.alm_pulse = 1'b0;
      r_next.cal_irq   = 1'b0;
      r_next.tmp_sync  = {r_reg.tmp_sync[1:0], tamper_input_n_i};
      r_next.bus_act   = hsel_i && htrans_i[1] && hready_i && haddr_i[31:11] == 21'h000000;
      r_next.bus_wr    = hwrite_i;
      r_next.bus_idx   = haddr_i[10:2];
      wr_stat          = r_reg.bus_act && r_reg.bus_wr && r_reg.bus_idx == `RAP_IDX_STATUS_LO;
      alm_fire = halfsec_tick_i && r_reg.cal_en && r_reg.alm_en && hit; // see (RL24) (RL23)
      pw_start = alm_fire && r_reg.pwc_en && r_reg.pw == rap_pkg::PW_IDLE;
      tmp_fall = r_reg.tmp_sync[2] && !r_reg.tmp_sync[1];
      ts_trig  = r_reg.ts_en && !r_reg.ts_flag && (tmp_fall || r_reg.ts_pend); // see (RL17) (RL19)
      if (r_reg.ts_pend) begin
         r_next.ts_pend = 1'b0;
      end

      // bus write, data phase
      if (r_reg.bus_act && r_reg.bus_wr) begin
         case (r_reg.bus_idx)
            `RAP_IDX_CAL_CTRL_LO: begin
               r_next.cal_en  = hwdata_i[`RAP_CC_CAL_EN];
               r_next.pwc_en  = hwdata_i[`RAP_CC_PWC_EN];
               r_next.pwc_pol = hwdata_i[`RAP_CC_PWC_POL];
               r_next.pin_oe  = hwdata_i[`RAP_CC_PIN_OE];
               r_next.outsel  = hwdata_i[`RAP_CC_OUTSEL];
               r_next.ts_en   = hwdata_i[`RAP_CC_TS_EN];
            end
            `RAP_IDX_ALM_CTRL_HI: begin
               r_next.alm_en = hwdata_i[`RAP_AC_ALM_EN];
               r_next.chime  = hwdata_i[`RAP_AC_CHIME];
               r_next.mask   = hwdata_i[`RAP_AC_MASK];
               r_next.rpt    = hwdata_i[`RAP_AC_RPT];
            end
            `RAP_IDX_CLK_CFG_LO: r_next.ps = hwdata_i[`RAP_CF_PWC_PS];
            `RAP_IDX_PWR_WIN: begin
               r_next.samp_len = hwdata_i[`RAP_PW_SAMP];
               r_next.stab_len = hwdata_i[`RAP_PW_STAB];
            end
            `RAP_IDX_STATUS_LO: begin
               if (!hwdata_i[`RAP_ST_TS_EVT]) begin
                  r_next.ts_flag = 1'b0;
               end else if (r_reg.ts_en && !r_reg.ts_flag) begin
                  r_next.ts_pend = 1'b1; // see (RL21)
               end
            end
            `RAP_IDX_ALM_TIME_LO: r_next.alm.timel = hwdata_i[15:0];
            `RAP_IDX_ALM_TIME_HI: r_next.alm.timeh = hwdata_i[15:0];
            `RAP_IDX_ALM_DATE_LO: r_next.alm.datel = hwdata_i[15:0];
            `RAP_IDX_ALM_DATE_HI: r_next.alm.dateh = hwdata_i[15:0];
            // capture words are plain storage only while timestamping is off
            `RAP_IDX_CAP_TIME_LO: if (!r_reg.ts_en) r_next.cap.timel = hwdata_i[15:0]; // see (RL20)
            `RAP_IDX_CAP_TIME_HI: if (!r_reg.ts_en) r_next.cap.timeh = hwdata_i[15:0];
            `RAP_IDX_CAP_DATE_LO: if (!r_reg.ts_en) r_next.cap.datel = hwdata_i[15:0];
            `RAP_IDX_CAP_DATE_HI: if (!r_reg.ts_en) r_next.cap.dateh = hwdata_i[15:0];
            default: ;
         endcase
      end

      // alarm event overrides a same-cycle software write of enable or count, whichever of the two it updates
      if (alm_fire) begin
         r_next.alm_pulse = 1'b1; // see (RL7)
         if (r_reg.rpt == `RAP_RPT_LAST) begin
            if (r_reg.chime) begin
               r_next.rpt = `RAP_RPT_ROLL; // see (RL6)
            end else begin
               r_next.alm_en = 1'b0; // see (RL1) (RL4)
            end
         end else begin
            r_next.rpt = r_reg.rpt - 8'h01; // see (RL5)
         end
      end

      // power-control sequencer
      unique case (r_reg.pw)
         rap_pkg::PW_IDLE: begin
            r_next.win_cnt = 8'h00;
            if (pw_start) begin
               if (r_reg.stab_len != `RAP_WIN_OFF) begin // see (RL15)
                  r_next.pw = rap_pkg::PW_STAB; // see (RL12)
               end else if (r_reg.samp_len != `RAP_WIN_OFF) begin
                  r_next.pw = rap_pkg::PW_SAMP;
               end
            end
         end
         rap_pkg::PW_STAB: begin
            if (ps_tick) begin
               r_next.win_cnt = r_reg.win_cnt + 8'h01; // see (RL13)
               if (r_next.win_cnt == r_reg.stab_len) begin
                  r_next.win_cnt = 8'h00;
                  r_next.pw = (r_reg.samp_len != `RAP_WIN_OFF) ? rap_pkg::PW_SAMP
                                                               : rap_pkg::PW_IDLE;
               end
            end
         end
         rap_pkg::PW_SAMP: begin
            if (ps_tick) begin
               r_next.win_cnt = r_reg.win_cnt + 8'h01;
               if (r_next.win_cnt == r_reg.samp_len) begin
                  r_next.win_cnt = 8'h00;
                  r_next.pw = rap_pkg::PW_IDLE; // see (RL12)
               end
            end
         end
      endcase
      // disabling power control or the calendar cuts a running cycle short
      if (!r_reg.pwc_en || !r_reg.cal_en) begin
         r_next.pw      = rap_pkg::PW_IDLE;
         r_next.win_cnt = 8'h00;
      end

      // timestamp capture; the set wins over a same-cycle clear
      if (ts_trig) begin
         r_next.cap     = cal_time_i; // see (RL18)
         r_next.ts_flag = 1'b1;
         r_next.cal_irq = 1'b1;
         r_next.ts_pend = 1'b0;
      end

      // read data sampled from the next state so a write just before is seen
      r_next.rdata = 32'h00000000;
      if (r_next.bus_act && !hwrite_i) begin
         r_next.rdata = rap_read(r_next, r_next.bus_idx);
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         r_reg <= RST_VAL;
         if (!por_i) begin
            r_reg.cap <= r_reg.cap; // see (RL20)
         end
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   always_comb begin
      pw_act            = r_reg.pw != rap_pkg::PW_IDLE;
      power_ctrl_o      = r_reg.pwc_pol ? pw_act : !pw_act; // see (RL10)
      sample_gate_o     = r_reg.pw == rap_pkg::PW_SAMP;
      stab_window_o     = pw_act || r_reg.stab_len == `RAP_WIN_HOLD; // see (RL16)
      clock_pin_o       = (r_reg.outsel == `RAP_OUTSEL_PWC) ? power_ctrl_o : 1'b0;
      clock_pin_oe_o    = r_reg.pin_oe;
      calendar_enable_o = r_reg.cal_en; // see (RL23)
      alarm_irq_o       = r_reg.alm_pulse;
      calendar_irq_o    = r_reg.cal_irq;
      hrdata_o          = r_reg.rdata;
      hreadyout_o       = 1'b1;
      hresp_o           = 1'b0;
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   a_alm_one_shot : assert property ( // see (RL1) (RL4)
      alm_fire && r_reg.rpt == 8'h00 && !r_reg.chime |=> !r_reg.alm_en)
      else $error("alarm enable not cleared after last alarm");
   a_rpt_dec_one : assert property ( // see (RL5)
      alm_fire && r_reg.rpt != 8'h00 |=> r_reg.rpt == $past(r_reg.rpt) - 8'h01)
      else $error("repeat count not decremented by one");
   a_rpt_roll_over : assert property ( // see (RL6)
      alm_fire && r_reg.rpt == 8'h00 && r_reg.chime |=> r_reg.rpt == 8'hff && r_reg.alm_en)
      else $error("chime did not roll count to ff");
   a_irq_from_tick : assert property ( // see (RL7) (RL24)
      alarm_irq_o |-> $past(halfsec_tick_i) && $past(r_reg.alm_en) && $past(r_reg.cal_en))
      else $error("alarm interrupt without enabled half-second tick");
   a_half_mask_fires : assert property ( // see (RL3)
      halfsec_tick_i && r_reg.mask == 4'h0 && r_reg.alm_en && r_reg.cal_en |=> alarm_irq_o)
      else $error("half-second mask did not fire");
   a_gate_polarity : assert property ( // see (RL10) (RL12)
      sample_gate_o |-> power_ctrl_o == r_reg.pwc_pol && stab_window_o)
      else $error("sample gate without active control output");
   a_seq_enter_stab : assert property ( // see (RL12) (RL15)
      pw_start && r_reg.stab_len != 8'h00 |=> r_reg.pw == rap_pkg::PW_STAB)
      else $error("power cycle did not open stability window");
   a_samp_zero_off : assert property ( // see (RL15)
      $rose(sample_gate_o) |-> $past(r_reg.samp_len) != 8'h00)
      else $error("sample window opened with zero length");
   a_ts_capture : assert property ( // see (RL17) (RL18)
      ts_trig |=> r_reg.ts_flag && calendar_irq_o && r_reg.cap == $past(cal_time_i))
      else $error("timestamp capture incomplete");
   a_ts_blocked : assert property ( // see (RL19)
      r_reg.ts_flag && r_reg.ts_en |=> $stable(r_reg.cap))
      else $error("capture changed while flag set");
   a_manual_start : assert property ( // see (RL21)
      wr_stat && hwdata_i[3] && r_reg.ts_en && !r_reg.ts_flag && !tmp_fall
      |=> !r_reg.ts_flag ##1 r_reg.ts_flag)
      else $error("manual capture flag timing wrong");

   c_chime_roll : cover property (alm_fire && r_reg.chime && r_reg.rpt == 8'h00);
   c_sample_done : cover property (sample_gate_o ##1 !sample_gate_o);
   c_ts_manual : cover property (ts_trig && r_reg.ts_pend);
   c_ts_tamper : cover property (ts_trig && !r_reg.ts_pend);

endmodule // rap_top
